// ### rtl/fbk_defs.svh
/*
 Timing counts, field positions, reset values and register offsets of the flash security block.
 Assumes inclusion by bare name from the design module; the package does not include it.
*/
`ifndef FBK_DEFS_SVH
`define FBK_DEFS_SVH

`define FBK_REG_CONFIG      4'h0
`define FBK_REG_STATUS      4'h1
`define FBK_REG_SECURITY    4'h2
`define FBK_REG_PROTECT     4'h3
`define FBK_REG_SECSTATE    4'h4
`define FBK_REG_ARRAY_DATA  4'h5

`define FBK_CFG_BEIE_BIT    7
`define FBK_CFG_COMMAND_COMPLETE_IRQ_ENABLE_BIT    6
`define FBK_CFG_KEY_ACCESS_BIT_BIT  5
`define FBK_STAT_BEIF_BIT   7
`define FBK_STAT_COMMAND_COMPLETE_FLAG_BIT   6

`define FBK_KEY_ENABLE_FIELD_OPEN      2'h2
`define FBK_SEC_UNSECURE    2'h2
`define FBK_KEY_BASE        16'hFF00
`define FBK_KEY_WORDS       4
`define FBK_SECBYTE_ADDR    16'hFF0F
`define FBK_PROTBYTE_ADDR   16'hFF0D
`define FBK_BAD_KEY_LO      16'h0000
`define FBK_BAD_KEY_HI      16'hFFFF
`define FBK_INVALID_DATA    16'h0000
`define FBK_STAT_RESET      8'hC0
`define FBK_CFG_RESET       8'h00

`define FBK_LOAD_NS         40
`define FBK_CLK_NS          8
`define FBK_LOAD_CYCLES     ((`FBK_LOAD_NS + `FBK_CLK_NS - 1) / `FBK_CLK_NS)

`endif

// ### rtl/fbk_pkg.sv
/*
 Types for the flash security block: key state machine and bus request carrier.
 Takes no numbers from fbk_defs.svh; the state codes are one-hot literals.
*/
package fbk_pkg;
	typedef enum logic [4:0] {
		FBK_LOAD   = 5'h01,
		FBK_IDLE   = 5'h02,
		FBK_KEYSEQ = 5'h04,
		FBK_DONE   = 5'h08,
		FBK_LOCK   = 5'h10
	} fbk_state_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [3:0]  addr;
		logic [15:0] wdata;
	} fbk_req_t;
endpackage : fbk_pkg

// ### rtl/fbk_security.sv
/*
 Flash backdoor key security logic: reset-time load of protection and security,
 key sequence checker, array-read gating, command abort and interrupt requests.
 Assumes a register port on clk_sys, key writes seen on the CPU write port,
 and an array read port whose data returns in the same cycle.
*/
// The plain strobed port and the register offsets are this design's own decisions.
`include "fbk_defs.svh"

module fbk_security
	import fbk_pkg::*;
#(
	parameter int LOAD_CYCLES = `FBK_LOAD_CYCLES
) (
	input  wire logic        clk_sys,
	input  wire logic        reset,
	input  wire logic [3:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [15:0]      reg_rdata,
	input  wire logic [15:0] cpu_addr,
	input  wire logic [15:0] cpu_wdata,
	input  wire logic        cpu_wr,
	input  wire logic        cpu_rd,
	output logic [15:0]      cpu_rdata,
	input  wire logic        background_debug_mode,
	input  wire logic        special_single_chip,
	input  wire logic        cmd_mass_erase,
	input  wire logic        cmd_valid,
	output logic             cmd_accept,
	output logic             cmd_abort,
	input  wire logic        cmd_active,
	input  wire logic        cmd_done,
	input  wire logic        buf_empty,
	output logic [15:0]      arr_addr,
	output logic [15:0]      arr_wdata,
	output logic             arr_wr,
	input  wire logic [15:0] arr_rdata,
	output logic             cpu_hold,
	output logic             secured,
	output logic             irq_buffer_empty,
	output logic             irq_cmd_complete
);
	fbk_req_t   req;
	fbk_state_t state_q;
	fbk_state_t state_d;
	logic [15:0] load_cnt_q;
	logic [1:0]  load_idx_q;
	logic [7:0]  security_register_q;
	logic [7:0]  protection_register_q;
	logic [7:0]  config_register_q;
	logic [7:0]  status_register_q;
	logic [1:0]  key_idx_q;
	logic        key_ok_q;
	logic        sec_forced_q;
	logic        bdm_s1_q;
	logic        bdm_q;
	logic        ssc_s1_q;
	logic        ssc_q;
	logic [15:0] reg_rdata_q;
	logic [15:0] cpu_rdata_q;
	logic        cmd_accept_q;
	logic        cmd_abort_q;
	logic        cpu_hold_q;
	logic        secured_q;
	logic        irq_be_q;
	logic        irq_cc_q;
	logic [15:0] stored_key [`FBK_KEY_WORDS];

	assign req = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};

	wire key_access_bit    = config_register_q[`FBK_CFG_KEY_ACCESS_BIT_BIT];
	wire [1:0] key_enable_field = security_register_q[7:6];
	wire [1:0] security_state_field = sec_forced_q ? `FBK_SEC_UNSECURE : security_register_q[1:0];
	wire is_secure         = security_state_field != `FBK_SEC_UNSECURE;
	wire key_region        = cpu_addr[15:3] == `FBK_KEY_BASE >> 3;
	wire [1:0] word_idx    = cpu_addr[2:1];
	wire key_write         = cpu_wr && key_region && state_q == FBK_KEYSEQ;
	wire key_enabled       = key_enable_field == `FBK_KEY_ENABLE_FIELD_OPEN && key_access_bit;
	wire debug_blocked     = bdm_q && ssc_q;
	wire bad_value         = cpu_wdata == `FBK_BAD_KEY_LO || cpu_wdata == `FBK_BAD_KEY_HI;
	wire word_match        = cpu_wdata == stored_key[word_idx] && !bad_value;
	wire in_order          = word_idx == key_idx_q && !key_ok_q;
	wire good_word         = word_match && in_order && !debug_blocked;
	wire cfg_wr            = req.wr && req.addr == `FBK_REG_CONFIG;
	wire stat_wr           = req.wr && req.addr == `FBK_REG_STATUS;
	wire [7:0] cfg_next    = cfg_wr ? req.wdata[7:0] : config_register_q;
	wire acc_drop          = !cfg_next[`FBK_CFG_KEY_ACCESS_BIT_BIT];
	wire loading           = state_q == FBK_LOAD;
	wire [15:0] load_addr  = load_idx_q == 2'h0 ? `FBK_PROTBYTE_ADDR : `FBK_SECBYTE_ADDR;
	wire cmd_ok            = !(is_secure && bdm_q && ssc_q) || cmd_mass_erase;
	wire arr_pass          = cpu_wr && !key_region || cpu_wr && key_region && !is_secure;
	wire be_flag           = status_register_q[`FBK_STAT_BEIF_BIT];
	wire cc_flag           = status_register_q[`FBK_STAT_COMMAND_COMPLETE_FLAG_BIT];
	wire [15:0] reg_mux    = req.addr == `FBK_REG_CONFIG   ? {8'h00, config_register_q} :
	                         req.addr == `FBK_REG_STATUS   ? {8'h00, status_register_q} :
	                         req.addr == `FBK_REG_SECURITY ? {8'h00, security_register_q} :
	                         req.addr == `FBK_REG_PROTECT  ? {8'h00, protection_register_q} :
	                         req.addr == `FBK_REG_SECSTATE ? {12'h000, state_q == FBK_LOCK,
	                                                          sec_forced_q, security_state_field} :
	                         16'h0000;

	always_comb begin
		state_d = state_q;
		case (state_q)
			FBK_LOAD:   if (load_idx_q == 2'h2) state_d = FBK_IDLE;
			FBK_IDLE:   if (key_enabled) state_d = FBK_KEYSEQ;
			FBK_KEYSEQ: begin
				if (key_write && !good_word) state_d = FBK_LOCK;
				else if (cfg_wr && acc_drop) state_d = key_ok_q ? FBK_DONE : FBK_LOCK;
				else if (!key_access_bit) state_d = FBK_LOCK;
			end
			FBK_DONE:   state_d = FBK_DONE;
			FBK_LOCK:   state_d = FBK_LOCK;
			default:    state_d = FBK_LOCK;
		endcase
	end

	// Synchronise the mode straps; they come from another block's timing.
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			bdm_s1_q <= 1'b0;
			bdm_q    <= 1'b0;
			ssc_s1_q <= 1'b0;
			ssc_q    <= 1'b0;
		end else begin
			bdm_s1_q <= background_debug_mode;
			bdm_q    <= bdm_s1_q;
			ssc_s1_q <= special_single_chip;
			ssc_q    <= ssc_s1_q;
		end
	end

	// Load sequence: wait the settle count, fetch protection then security byte.
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			load_cnt_q            <= 16'h0000;
			load_idx_q            <= 2'h0;
			protection_register_q <= 8'hFF;
			security_register_q   <= 8'hFF;
		end else if (loading) begin
			if (load_cnt_q < LOAD_CYCLES[15:0]) begin
				load_cnt_q <= load_cnt_q + 16'h0001;
			end else if (load_idx_q == 2'h0) begin
				protection_register_q <= arr_rdata[7:0];
				load_idx_q            <= 2'h1;
			end else begin
				security_register_q <= arr_rdata[7:0];
				load_idx_q          <= 2'h2;
			end
		end
	end

	// The key comparator reads a shadow of the key words, refreshed by each key write that reaches the array and each key read made without the key access bit.
	genvar gi;
	for (gi = 0; gi < `FBK_KEY_WORDS; gi++) begin : g_key
		always_ff @(posedge clk_sys or posedge reset) begin
			if (reset) begin
				stored_key[gi] <= `FBK_BAD_KEY_HI;
			end else if ((cpu_wr && arr_pass && key_region && word_idx == gi) || (cpu_rd && key_region
			             && word_idx == gi && !key_access_bit)) begin
				stored_key[gi] <= cpu_wr ? cpu_wdata : arr_rdata;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			state_q      <= FBK_LOAD;
			key_idx_q    <= 2'h0;
			key_ok_q     <= 1'b0;
			sec_forced_q <= 1'b0;
		end else begin
			state_q <= state_d;
			if (key_write && good_word) begin
				key_idx_q <= key_idx_q + 2'h1;
				key_ok_q  <= key_idx_q == 2'h3;
			end
			if (state_q == FBK_KEYSEQ && state_d == FBK_DONE) sec_forced_q <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			config_register_q <= `FBK_CFG_RESET;
		end else if (cfg_wr) begin
			config_register_q <= {req.wdata[7:5], 5'h00};
		end
	end

	// Hardware sets take priority over a software write-one-to-clear.
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			status_register_q <= `FBK_STAT_RESET;
		end else begin
			status_register_q[7] <= buf_empty | (be_flag & ~(stat_wr & req.wdata[7]));
			status_register_q[6] <= cmd_done | (!cmd_active & cc_flag & ~(stat_wr & req.wdata[6]));
			status_register_q[5:0] <= 6'h00;
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			reg_rdata_q  <= 16'h0000;
			cpu_rdata_q  <= 16'h0000;
			cmd_accept_q <= 1'b0;
			cmd_abort_q  <= 1'b1;
			cpu_hold_q   <= 1'b1;
			secured_q    <= 1'b1;
			irq_be_q     <= 1'b0;
			irq_cc_q     <= 1'b0;
		end else begin
			reg_rdata_q  <= req.rd ? reg_mux : 16'h0000;
			cpu_rdata_q  <= key_access_bit ? `FBK_INVALID_DATA : arr_rdata;
			cmd_accept_q <= cmd_valid && cmd_ok && !loading;
			cmd_abort_q  <= loading;
			cpu_hold_q   <= state_d == FBK_LOAD;
			secured_q    <= is_secure;
			irq_be_q     <= be_flag && config_register_q[`FBK_CFG_BEIE_BIT];
			irq_cc_q     <= cc_flag && config_register_q[`FBK_CFG_COMMAND_COMPLETE_IRQ_ENABLE_BIT];
		end
	end

	assign reg_rdata        = reg_rdata_q;
	assign cpu_rdata        = cpu_rdata_q;
	assign cmd_accept       = cmd_accept_q;
	assign cmd_abort        = cmd_abort_q;
	assign cpu_hold         = cpu_hold_q;
	assign secured          = secured_q;
	assign irq_buffer_empty = irq_be_q;
	assign irq_cmd_complete = irq_cc_q;
	assign arr_addr         = loading ? load_addr : cpu_addr;
	assign arr_wdata        = cpu_wdata;
	assign arr_wr           = arr_pass && !loading;

	a_lock_sticky: assert property (@(posedge clk_sys) disable iff (reset)
		state_q == FBK_LOCK |=> state_q == FBK_LOCK)
		else $error("lock state left without reset");
	a_lock_no_unsec: assert property (@(posedge clk_sys) disable iff (reset)
		state_q == FBK_LOCK && !sec_forced_q |=> !sec_forced_q)
		else $error("security changed while locked");
	a_bad_word_lock: assert property (@(posedge clk_sys) disable iff (reset)
		key_write && bad_value |=> state_q == FBK_LOCK)
		else $error("invalid key value did not lock");
	a_order_lock: assert property (@(posedge clk_sys) disable iff (reset)
		key_write && !in_order |=> state_q == FBK_LOCK)
		else $error("out of order key word did not lock");
	a_unsec_needs_four: assert property (@(posedge clk_sys) disable iff (reset)
		$rose(sec_forced_q) |-> $past(key_ok_q) && state_q == FBK_DONE)
		else $error("unsecured without four matching words");
	a_stored_kept: assert property (@(posedge clk_sys) disable iff (reset)
		!loading && !$past(loading) |-> $stable(security_register_q))
		else $error("stored security byte altered");
	a_prot_kept: assert property (@(posedge clk_sys) disable iff (reset)
		!loading && !$past(loading) |-> $stable(protection_register_q))
		else $error("protection altered outside load");
	a_read_invalid: assert property (@(posedge clk_sys) disable iff (reset)
		key_access_bit |=> cpu_rdata == `FBK_INVALID_DATA)
		else $error("array data leaked during key access");
	a_hold_load: assert property (@(posedge clk_sys) disable iff (reset)
		state_q == FBK_LOAD && state_d == FBK_LOAD |=> cpu_hold)
		else $error("cpu not held during load");
	a_irq_cc: assert property (@(posedge clk_sys) disable iff (reset)
		cc_flag && config_register_q[`FBK_CFG_COMMAND_COMPLETE_IRQ_ENABLE_BIT] |=> irq_cmd_complete)
		else $error("command complete interrupt missing");

	a_irq_be: assert property (@(posedge clk_sys) disable iff (reset)
		be_flag && config_register_q[`FBK_CFG_BEIE_BIT] |=> irq_buffer_empty)
		else $error("buffer empty interrupt missing");
	a_irq_quiet: assert property (@(posedge clk_sys) disable iff (reset)
		!config_register_q[`FBK_CFG_BEIE_BIT] |=> !irq_buffer_empty)
		else $error("buffer empty interrupt raised while disabled");
	// A flag event in the same cycle as a software clear must leave the flag set.
	a_set_wins: assert property (@(posedge clk_sys) disable iff (reset)
		buf_empty |=> be_flag)
		else $error("buffer empty flag lost to a clear");
	a_cc_set_wins: assert property (@(posedge clk_sys) disable iff (reset)
		cmd_done |=> cc_flag)
		else $error("command complete flag lost to a clear");
	a_abort_load: assert property (@(posedge clk_sys) disable iff (reset)
		loading |=> cmd_abort)
		else $error("command not aborted during load");
	a_mass_only: assert property (@(posedge clk_sys) disable iff (reset)
		cmd_valid && is_secure && debug_blocked && !cmd_mass_erase |=> !cmd_accept)
		else $error("secured debug command other than mass erase accepted");
	a_debug_lock: assert property (@(posedge clk_sys) disable iff (reset)
		key_write && debug_blocked |=> state_q == FBK_LOCK)
		else $error("debug key write did not lock");
	a_drop_lock: assert property (@(posedge clk_sys) disable iff (reset)
		state_q == FBK_KEYSEQ && cfg_wr && acc_drop && !key_ok_q |=> state_q == FBK_LOCK)
		else $error("early access drop did not lock");
	a_access_lost: assert property (@(posedge clk_sys) disable iff (reset)
		state_q == FBK_KEYSEQ && !key_access_bit |=> state_q == FBK_LOCK)
		else $error("key sequence kept without access bit");
	a_unlock_clears: assert property (@(posedge clk_sys) disable iff (reset)
		state_q == FBK_DONE |=> !secured)
		else $error("secured output kept after unlock");
	a_key_gate: assert property (@(posedge clk_sys) disable iff (reset)
		state_q == FBK_KEYSEQ |-> key_enable_field == `FBK_KEY_ENABLE_FIELD_OPEN)
		else $error("key sequence entered with key enable closed");
	a_arr_key_guard: assert property (@(posedge clk_sys) disable iff (reset)
		arr_wr && key_region |-> !is_secure)
		else $error("key bytes written while secured");

	// Counts held cycles, so a load that never finishes is caught rather than stalling the CPU silently.
	logic [15:0] hold_len_q;
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			hold_len_q <= 16'h0000;
		end else if (cpu_hold_q) begin
			hold_len_q <= hold_len_q + 16'h0001;
		end else begin
			hold_len_q <= 16'h0000;
		end
	end
	a_load_ends: assert property (@(posedge clk_sys) disable iff (reset)
		hold_len_q <= 16'(LOAD_CYCLES + 4))
		else $error("load sequence did not end");

	c_unlock: cover property (@(posedge clk_sys) disable iff (reset) $rose(sec_forced_q));
	c_lock: cover property (@(posedge clk_sys) disable iff (reset) $rose(state_q == FBK_LOCK));
	c_irq_be: cover property (@(posedge clk_sys) disable iff (reset) $rose(irq_buffer_empty));
	c_irq_cc: cover property (@(posedge clk_sys) disable iff (reset) $rose(irq_cmd_complete));
	c_cmd_refused: cover property (@(posedge clk_sys) disable iff (reset)
		cmd_valid && debug_blocked && is_secure && !cmd_mass_erase);
endmodule : fbk_security

// ### sim/fbk_array_model.sv
/*
 Behavioural flash array facing the security block: backdoor key words, protection and security bytes.
 Assumes byte addresses on arr_addr and same-cycle read data; the bench picks the stored bytes.
*/
module fbk_array_model (
	input  wire logic [15:0] arr_addr,
	input  wire logic [7:0]  sec_byte,
	input  wire logic [7:0]  prot_byte,
	output logic [15:0]      arr_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [63:0] KEYS = 64'hDEF1_9ABC_5678_1234;
	// Bytes are mirrored in both lanes so either lane choice in the block reads the right value.
	always_comb begin
		if (arr_addr[15:3] == 13'h1FE0) begin
			arr_rdata = KEYS[16*arr_addr[2:1] +: 16];
		end else if (arr_addr == 16'hFF0D) begin
			arr_rdata = {prot_byte, prot_byte};
		end else if (arr_addr == 16'hFF0F) begin
			arr_rdata = {sec_byte, sec_byte};
		end else begin
			arr_rdata = ~arr_addr;
		end
	end
endmodule : fbk_array_model

// ### sim/test_flash_backdoor_unlock_irq.sv
/*
 Self-checking bench for the flash security block: load, key sequences, locking, gating, commands, interrupts.
 Assumes the array model answers reads; key words are primed by CPU reads before each attempt.
*/
module test_flash_backdoor_unlock_irq
	import fbk_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [63:0] KEYS = 64'hDEF1_9ABC_5678_1234;
	logic        clk_sys, reset, reg_wr, reg_rd, cpu_wr, cpu_rd, cmd_accept, cmd_abort, arr_wr;
	logic        background_debug_mode, special_single_chip, cmd_mass_erase, cmd_valid;
	logic        cmd_active, cmd_done, buf_empty, cpu_hold, secured, irq_buffer_empty, irq_cmd_complete;
	logic [3:0]  reg_addr;
	logic [15:0] reg_wdata, reg_rdata, cpu_addr, cpu_wdata, cpu_rdata, arr_addr, arr_wdata, arr_rdata;
	logic [7:0]  sec_byte, prot_byte;
	int          n_errors, checks_done, c;
	int          key_wr_cnt  = 0;
	logic [15:0] key_wr_data = 16'h0000;

	fbk_security dut (.clk_sys, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cpu_addr,
		.cpu_wdata, .cpu_wr, .cpu_rd, .cpu_rdata, .background_debug_mode, .special_single_chip,
		.cmd_mass_erase, .cmd_valid, .cmd_accept, .cmd_abort, .cmd_active, .cmd_done, .buf_empty,
		.arr_addr, .arr_wdata, .arr_wr, .arr_rdata, .cpu_hold, .secured, .irq_buffer_empty,
		.irq_cmd_complete);
	fbk_array_model flash (.arr_addr, .sec_byte, .prot_byte, .arr_rdata);

	// Records array writes into the key range; only an unsecured part may reach them.
	always @(posedge clk_sys) begin
		if (arr_wr === 1'b1 && arr_addr[15:3] == 13'h1FE0) begin
			key_wr_cnt  <= key_wr_cnt + 1;
			key_wr_data <= arr_wdata;
		end
	end

	always #4 clk_sys = ~clk_sys;

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : wrap_up

	task automatic reg_acc(input logic wr, input logic [3:0] a, input logic [15:0] d, input logic [15:0] exp);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= wr;
		reg_rd <= !wr;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		#1;
		if (!wr) chk(reg_rdata, exp);
	endtask : reg_acc

	task automatic cpu_acc(input logic wr, input logic [15:0] a, input logic [15:0] d, input logic [15:0] exp);
		@(posedge clk_sys);
		cpu_addr <= a;
		cpu_wdata <= d;
		cpu_wr <= wr;
		cpu_rd <= !wr;
		@(posedge clk_sys);
		cpu_wr <= 1'b0;
		cpu_rd <= 1'b0;
		#1;
		if (!wr) chk(cpu_rdata, exp);
	endtask : cpu_acc

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : wait_cyc

	// A command is running when reset hits; reset forces the abort output high whatever cmd_active is.
	task automatic do_reset();
		int i;
		cmd_active <= 1'b1;
		reset <= 1'b1;
		wait_cyc(8);
		chk({cpu_hold, cmd_abort, secured}, 3'b111);
		reset <= 1'b0;
		cmd_active <= 1'b0;
		for (i = 0; i < 40 && cpu_hold !== 1'b0; i++) wait_cyc(1);
		wait_cyc(1);
		chk({cpu_hold, cmd_abort}, 2'b00);
		for (i = 0; i < 4; i++) cpu_acc(0, 16'hFF00 + 16'(2*i), 0, KEYS[16*i +: 16]);
	endtask : do_reset

	// Kind 3 swaps word order, 4 sends a fifth word, 5 drops access after two words, 6 is correct.
	task automatic attempt(input int k);
		int n;
		int idx;
		logic [15:0] w;
		reg_acc(1, 4'h0, 16'h0020, 0);
		for (n = 0; n < (k == 4 ? 5 : k == 5 ? 2 : 4); n++) begin
			idx = k == 3 ? n ^ 1 : (n > 3 ? 3 : n);
			w = KEYS[16*idx +: 16];
			if (k == 0 && n == 1) w = w ^ 16'h0001;
			if (k == 1 && n == 2) w = 16'h0000;
			if (k == 2 && n == 3) w = 16'hFFFF;
			cpu_acc(1, 16'hFF00 + 16'(2*idx), w, 0);
		end
		reg_acc(1, 4'h0, 16'h0000, 0);
		wait_cyc(3);
	endtask : attempt

	task automatic cmd_req(input logic me, input logic exp);
		@(posedge clk_sys);
		cmd_valid <= 1'b1;
		cmd_mass_erase <= me;
		@(posedge clk_sys);
		cmd_valid <= 1'b0;
		#1;
		chk(cmd_accept, exp);
	endtask : cmd_req

	initial begin
		repeat (20000) @(posedge clk_sys);
		n_errors++;
		wrap_up();
	end

	initial begin
		{clk_sys, reg_wr, reg_rd, cpu_wr, cpu_rd, cmd_mass_erase, cmd_valid, cmd_done, buf_empty} = '0;
		{background_debug_mode, special_single_chip, reg_addr, reg_wdata, cpu_addr, cpu_wdata} = '0;
		{n_errors, checks_done} = '0;
		reset = 1'b1;
		cmd_active = 1'b1;
		sec_byte = 8'h80;
		prot_byte = 8'hA5;
		do_reset();
		chk(secured, 1'b1);
		chk({irq_buffer_empty, irq_cmd_complete}, 2'b00);
		reg_acc(0, 4'h1, 0, 16'h00C0);
		reg_acc(0, 4'h2, 0, 16'h0080);
		reg_acc(0, 4'h3, 0, 16'h00A5);
		buf_empty <= 1'b1;
		cmd_done <= 1'b1;
		reg_acc(1, 4'h0, 16'h00C0, 0);
		wait_cyc(2);
		chk({irq_buffer_empty, irq_cmd_complete}, 2'b11);
		reg_acc(1, 4'h1, 16'h00C0, 0);
		reg_acc(0, 4'h1, 0, 16'h00C0);
		buf_empty <= 1'b0;
		cmd_done <= 1'b0;
		reg_acc(1, 4'h1, 16'h00C0, 0);
		wait_cyc(2);
		chk({irq_buffer_empty, irq_cmd_complete}, 2'b00);
		for (c = 0; c < 6; c++) begin
			do_reset();
			attempt(c);
			chk(secured, 1'b1);
			attempt(6);
			chk(secured, 1'b1);
		end
		sec_byte <= 8'hC0;
		do_reset();
		reg_acc(1, 4'h0, 16'h0020, 0);
		cpu_acc(0, 16'hFF00, 0, 16'h0000);
		attempt(6);
		chk(secured, 1'b1);
		sec_byte <= 8'h80;
		background_debug_mode <= 1'b1;
		special_single_chip <= 1'b1;
		do_reset();
		attempt(6);
		chk(secured, 1'b1);
		cmd_req(1'b0, 1'b0);
		cmd_req(1'b1, 1'b1);
		background_debug_mode <= 1'b0;
		special_single_chip <= 1'b0;
		do_reset();
		attempt(6);
		chk(secured, 1'b0);
		reg_acc(0, 4'h4, 0, 16'h0006);
		reg_acc(0, 4'h2, 0, 16'h0080);
		reg_acc(0, 4'h3, 0, 16'h00A5);
		reg_acc(0, 4'hF, 0, 16'h0000);
		chk(16'(key_wr_cnt), 16'h0000);
		cpu_acc(1, 16'hFF02, 16'h4321, 0);
		chk(16'(key_wr_cnt), 16'h0001);
		chk(key_wr_data, 16'h4321);
		do_reset();
		chk(secured, 1'b1);
		sec_byte <= 8'h82;
		do_reset();
		chk(secured, 1'b0);
		wrap_up();
	end
endmodule : test_flash_backdoor_unlock_irq
